// ==== core/clmp_pkg.sv ====
// Purpose: shared constants and types for the closed-loop margin pwm block
// Assumes: 125 MHz system clock, per-rail voltage samples from an outside adc
// Notes:   duty and voltage codes are unsigned; frequencies are set as period counts
`default_nettype none
package clmp_pkg;
	localparam int unsigned CLK_HZ         = 125000000;            // system clock rate
	localparam int unsigned PWM_MIN_HZ     = 1000;                 // slowest pwm
	localparam int unsigned PWM_MAX_HZ     = 1000000;              // fastest pwm
	localparam int unsigned PER_MAX_CYC    = CLK_HZ / PWM_MIN_HZ;  // longest period
	localparam int unsigned PER_MIN_CYC    = CLK_HZ / PWM_MAX_HZ;  // shortest period
	localparam int unsigned PER_W          = 17;                   // period counter width
	localparam int unsigned DUTY_W         = 16;                   // duty fraction, full = all ones
	localparam int unsigned VOLT_W         = 16;                   // voltage code width
	localparam int unsigned LOOP_DIV_DEF   = 125000;               // loop step every 1 ms
	localparam logic [DUTY_W-1:0] DUTY_RST = 16'h8000;             // loop duty at reset
	localparam logic [DUTY_W-1:0] DUTY_STEP = 16'h0001;            // one loop step

	// idle behaviour of a margin pin when not margining
	typedef enum logic [1:0] {
		CLMP_IDLE_TRI   = 2'b00,
		CLMP_IDLE_TRIM  = 2'b01,
		CLMP_IDLE_FIXED = 2'b10
	} clmp_idle_t;

	// per-rail configuration
	typedef struct packed {
		clmp_idle_t        idle_mode;     // behaviour when not margining
		logic [PER_W-1:0]  period;        // pwm period in clocks
		logic [DUTY_W-1:0] fixed_duty;    // duty in fixed-duty idle
		logic              inc_raises;    // duty up raises voltage
		logic              ign_flt_pin;   // ignore ov/uv while pin-margined
		logic [VOLT_W-1:0] v_nom;         // nominal target
		logic [VOLT_W-1:0] v_high;        // margin-high target
		logic [VOLT_W-1:0] v_low;         // margin-low target
	} clmp_cfg_t;

	// clamp a period into the legal frequency range
	function automatic logic [PER_W-1:0] clmp_per_clamp(input logic [PER_W-1:0] p);
		if (p < PER_MIN_CYC[PER_W-1:0])
			return PER_MIN_CYC[PER_W-1:0];
		if (p > PER_MAX_CYC[PER_W-1:0])
			return PER_MAX_CYC[PER_W-1:0];
		return p;
	endfunction
endpackage
`default_nettype wire

// ==== core/clmp_rail.sv ====
// Purpose: one rail: slow duty loop plus pwm generator with tri-state idle
// Assumes: inputs synchronous to sys_clk_in; rst_n already synchronised
// Notes:   loop steps by one code per loop tick to stay far below supply bandwidth
`default_nettype none
module clmp_rail #(
	parameter int unsigned LOOP_DIV = clmp_pkg::LOOP_DIV_DEF
) (
	input  wire logic                            clk_in,
	input  wire logic                            rst_n_in,
	input  wire logic                            ce_in,
	input  wire logic                            loop_tick_in,
	input  wire clmp_pkg::clmp_cfg_t             cfg_in,
	input  wire logic                            margin_in,
	input  wire logic                            high_in,
	input  wire logic                            pin_ctl_in,
	input  wire logic [clmp_pkg::VOLT_W-1:0]     vout_in,
	input  wire logic                            ov_in,
	input  wire logic                            uv_in,
	output logic                                 pwm_out,
	output logic                                 pwm_oe_out,
	output logic                                 fault_out
);
	logic [clmp_pkg::DUTY_W-1:0] duty_reg, duty_next;   // closed-loop duty
	logic [clmp_pkg::PER_W-1:0]  cnt_reg, cnt_next;     // pwm phase counter
	logic                        pwm_reg, pwm_next;
	logic                        oe_reg, oe_next;
	logic                        flt_reg, flt_next;

	wire logic [clmp_pkg::PER_W-1:0] per_w = clmp_pkg::clmp_per_clamp(cfg_in.period);
	// loop runs while margining or in trim idle
	wire logic closed_w = margin_in || (cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_TRIM);
	wire logic [clmp_pkg::VOLT_W-1:0] tgt_w = !margin_in ? cfg_in.v_nom :
		(high_in ? cfg_in.v_high : cfg_in.v_low);
	wire logic low_w  = vout_in < tgt_w;
	wire logic over_w = vout_in > tgt_w;
	// duty direction follows polarity setting
	wire logic up_w   = cfg_in.inc_raises ? low_w : over_w;
	wire logic dn_w   = cfg_in.inc_raises ? over_w : low_w;
	wire logic dmax_w = &duty_reg;
	wire logic dmin_w = ~|duty_reg;
	// duty actually used: fixed value in fixed idle, loop value otherwise
	wire logic [clmp_pkg::DUTY_W-1:0] duty_use_w = (!margin_in &&
		cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_FIXED) ? cfg_in.fixed_duty : duty_reg;
	// compare threshold scaled into period counts
	wire logic [clmp_pkg::PER_W+clmp_pkg::DUTY_W-1:0] prod_w =
		per_w * duty_use_w;
	wire logic [clmp_pkg::PER_W-1:0] thr_w =
		prod_w[clmp_pkg::PER_W+clmp_pkg::DUTY_W-1:clmp_pkg::DUTY_W];
	wire logic full_w = &duty_use_w;

	// next-state decode
	always_comb begin
		duty_next = duty_reg;
		// one small step per slow tick only
		if (closed_w && loop_tick_in) begin
			if (up_w && !dmax_w)
				duty_next = duty_reg + clmp_pkg::DUTY_STEP;
			else if (dn_w && !dmin_w)
				duty_next = duty_reg - clmp_pkg::DUTY_STEP;
		end
		cnt_next = (cnt_reg >= per_w - 17'h00001) ? '0 : cnt_reg + 17'h00001;
		pwm_next = full_w || (cnt_next < thr_w);
		// tri-state only when idle in tri-state mode
		oe_next  = margin_in || (cfg_in.idle_mode != clmp_pkg::CLMP_IDLE_TRI);
		// faults masked while pin-margined if asked
		flt_next = (ov_in || uv_in) && !(margin_in && pin_ctl_in && cfg_in.ign_flt_pin);
	end

	// state registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			duty_reg <= clmp_pkg::DUTY_RST;
			cnt_reg  <= '0;
			pwm_reg  <= 1'b0;
			oe_reg   <= 1'b0;
			flt_reg  <= 1'b0;
		end else if (ce_in) begin
			duty_reg <= duty_next;
			cnt_reg  <= cnt_next;
			pwm_reg  <= pwm_next & oe_next;
			oe_reg   <= oe_next;
			flt_reg  <= flt_next;
		end
	end

	assign pwm_out    = pwm_reg;
	assign pwm_oe_out = oe_reg;
	assign fault_out  = flt_reg;

	// duty moves only on a loop tick
	duty_slow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!loop_tick_in |=> $stable(duty_reg)) else $error("duty moved off tick");
	tri_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && !margin_in && cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_TRI)
		|=> !pwm_oe_out) else $error("pin driven in tri idle");
	drive_marg_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && margin_in) |=> pwm_oe_out) else $error("margin pin not driven");
	fixed_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(loop_tick_in && !margin_in && cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_FIXED)
		|=> $stable(duty_reg)) else $error("loop ran in fixed idle");
	pol_up_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && loop_tick_in && margin_in && cfg_in.inc_raises && low_w && !dmax_w)
		|=> duty_reg == $past(duty_reg) + clmp_pkg::DUTY_STEP)
		else $error("duty not raised");
	pol_dn_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && loop_tick_in && margin_in && !cfg_in.inc_raises && low_w && !dmin_w)
		|=> duty_reg == $past(duty_reg) - clmp_pkg::DUTY_STEP)
		else $error("inverted duty wrong");
	trim_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && loop_tick_in && !margin_in && cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_TRIM
		&& cfg_in.inc_raises && vout_in < cfg_in.v_nom && !dmax_w)
		|=> duty_reg != $past(duty_reg)) else $error("trim idle");
	flt_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && margin_in && pin_ctl_in && cfg_in.ign_flt_pin) |=> !fault_out)
		else $error("fault not ignored");
	per_rng_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cnt_reg < clmp_pkg::PER_MAX_CYC) else $error("period too long");
	marg_cov_c: cover property (@(posedge clk_in) margin_in && high_in && loop_tick_in);
	trim_cov_c: cover property (@(posedge clk_in)
		!margin_in && cfg_in.idle_mode == clmp_pkg::CLMP_IDLE_TRIM && loop_tick_in);
	pin_cov_c:  cover property (@(posedge clk_in) margin_in && pin_ctl_in);
endmodule
`default_nettype wire

// ==== core/clmp_top.sv ====
// Purpose: closed-loop margining of up to 24 rails, one pwm pin each
// Assumes: per-rail voltage samples and ov/uv flags arrive synchronous
// Notes:   bus and pin command sources are merged here; rails work alone
`default_nettype none
module clmp_top #(
	parameter int unsigned N_RAILS  = 24,                       // margined rails
	parameter int unsigned LOOP_DIV = clmp_pkg::LOOP_DIV_DEF    // clocks per loop step
) (
	input  wire logic                                sys_clk_in,
	input  wire logic                                rst_n_in,
	input  wire logic                                ce_in,
	input  wire clmp_pkg::clmp_cfg_t [N_RAILS-1:0]   cfg_in,
	input  wire logic [N_RAILS-1:0]                  pin_sel_in,
	input  wire logic [N_RAILS-1:0]                  bus_margin_in,
	input  wire logic [N_RAILS-1:0]                  bus_high_in,
	input  wire logic                                pin_en_in,
	input  wire logic                                pin_high_in,
	input  wire logic [N_RAILS*clmp_pkg::VOLT_W-1:0] vout_in,
	input  wire logic [N_RAILS-1:0]                  ov_in,
	input  wire logic [N_RAILS-1:0]                  uv_in,
	output logic      [N_RAILS-1:0]                  pwm_out,
	output logic      [N_RAILS-1:0]                  pwm_oe_out,
	output logic      [N_RAILS-1:0]                  fault_out,
	output logic      [N_RAILS-1:0]                  margining_out
);
	logic                  rst_s1_reg, rst_s2_reg;    // reset release synchroniser
	logic [31:0]           div_reg;                   // loop tick divider
	logic                  tick_reg;
	logic [N_RAILS-1:0]    marg_reg, high_reg;        // registered command

	// release reset through two flops
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// merge bus and pin sources; pin rails follow the pins only
	wire logic [N_RAILS-1:0] marg_w = (pin_sel_in & {N_RAILS{pin_en_in}}) |
		(~pin_sel_in & bus_margin_in);
	wire logic [N_RAILS-1:0] high_w = (pin_sel_in & {N_RAILS{pin_high_in}}) |
		(~pin_sel_in & bus_high_in);

	// slow loop tick, shared by all rails so they step together
	always_ff @(posedge sys_clk_in or negedge rst_s2_reg) begin
		if (!rst_s2_reg) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
			marg_reg <= '0;
			high_reg <= '0;
		end else if (ce_in) begin
			tick_reg <= (div_reg == LOOP_DIV - 1);
			div_reg  <= (div_reg == LOOP_DIV - 1) ? '0 : div_reg + 32'h00000001;
			marg_reg <= marg_w;
			high_reg <= high_w;
		end
	end

	assign margining_out = marg_reg;

	// one rail engine per margined output
	for (genvar i = 0; i < N_RAILS; i++) begin : g_rail
		clmp_rail #(.LOOP_DIV(LOOP_DIV)) u_rail (
			.clk_in       (sys_clk_in),
			.rst_n_in     (rst_s2_reg),
			.ce_in        (ce_in),
			.loop_tick_in (tick_reg & ce_in),
			.cfg_in       (cfg_in[i]),
			.margin_in    (marg_reg[i]),
			.high_in      (high_reg[i]),
			.pin_ctl_in   (pin_sel_in[i]),
			.vout_in      (vout_in[i*clmp_pkg::VOLT_W +: clmp_pkg::VOLT_W]),
			.ov_in        (ov_in[i]),
			.uv_in        (uv_in[i]),
			.pwm_out      (pwm_out[i]),
			.pwm_oe_out   (pwm_oe_out[i]),
			.fault_out    (fault_out[i])
		);
	end

	pin_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s2_reg)
		(ce_in && pin_sel_in[0] && pin_en_in) |=> margining_out[0])
		else $error("pin enable ignored");
	bus_cmd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s2_reg)
		(ce_in && !pin_sel_in[0]) |=> margining_out[0] == $past(bus_margin_in[0]))
		else $error("bus command ignored");
	tick_cov_c: cover property (@(posedge sys_clk_in) tick_reg);
endmodule
`default_nettype wire

// ==== testbench/clmp_fb_model.sv ====
// Purpose: behavioural feedback node of the margined supplies
// Assumes: filtered pwm moves the rail by one code per clock
// Notes:   a floated pin leaves the rail where it is, like an open resistor
`default_nettype none
module clmp_fb_model #(
	parameter int N = 2
) (
	input  wire logic            clk_in,
	input  wire logic [N-1:0]    pwm_in,
	input  wire logic [N-1:0]    oe_in,
	input  wire logic [N-1:0]    raises_in,
	output logic      [N*16-1:0] vout_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial vout_out = {N{16'h8000}};
	// integrate the driven level; polarity picks the sign of the pull
	always @(posedge clk_in) begin
		for (int i = 0; i < N; i++)
			if (oe_in[i])
				vout_out[16*i+:16] <= vout_out[16*i+:16]
					+ ((pwm_in[i] ~^ raises_in[i]) ? 16'h0001 : 16'hFFFF);
	end
endmodule
`default_nettype wire

// ==== testbench/tb_clmp_top.sv ====
// Purpose: self-checking bench for the margin pwm block, two rails
// Assumes: loop divider shortened to 4 clocks so duty drift is visible
// Notes:   duty is read back by counting high clocks over one period
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_clmp_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                         sys_clk = 1'b0;  // 125 MHz
	logic                         rst_n   = 1'b0;  // active low reset
	clmp_pkg::clmp_cfg_t [1:0]    cfg;             // per-rail setup
	logic [1:0]                   sel = 2'b00, bm = 2'b00, bh = 2'b00, ov = 2'b00, uv = 2'b00;
	logic                         pen = 1'b0, phi = 1'b0;
	logic                         ce  = 1'b1;      // clock enable, low freezes the block
	logic [31:0]                  vout;            // from the feedback model
	logic [1:0]                   pwm, oe, flt, mrg;
	logic [1:0]                   pq;              // pwm snapshot while frozen
	int                           err_count = 0, n_compared = 0, cyc = 0, n0, n1;
	always #4 sys_clk = ~sys_clk;
	clmp_top #(.N_RAILS(2), .LOOP_DIV(4)) DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
		.ce_in(ce), .cfg_in(cfg), .pin_sel_in(sel), .bus_margin_in(bm), .bus_high_in(bh),
		.pin_en_in(pen), .pin_high_in(phi), .vout_in(vout), .ov_in(ov), .uv_in(uv),
		.pwm_out(pwm), .pwm_oe_out(oe), .fault_out(flt), .margining_out(mrg));
	clmp_fb_model #(.N(2)) FB (.clk_in(sys_clk), .pwm_in(pwm), .oe_in(oe),
		.raises_in({cfg[1].inc_raises, cfg[0].inc_raises}), .vout_out(vout));
	// build a rail setup; margin targets sit far away so the loop keeps stepping, nominal sits at the model's start level
	function automatic clmp_pkg::clmp_cfg_t mk(input clmp_pkg::clmp_idle_t m,
		input logic [16:0] p, input logic [15:0] d, input logic inc, input logic ign);
		return '{m, p, d, inc, ign, 16'h8000, 16'hFFF0, 16'h0010};
	endfunction
	// step n edges, then move off the edge before driving
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// count high clocks of one rail over a window, looked at once settled after each edge
	task automatic cnt(input int r, input int c, output int n);
		n = 0;
		repeat (c) begin
			@(posedge sys_clk);
			#1;
			n += (pwm[r] === 1'b1) ? 1 : 0;
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, well above the roughly 22k clocks of the tests
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		cfg[0] = mk(clmp_pkg::CLMP_IDLE_TRI, 17'h000C8, 16'h0000, 1'b1, 1'b1);
		cfg[1] = mk(clmp_pkg::CLMP_IDLE_FIXED, 17'h000C8, 16'h4000, 1'b1, 1'b1);
		tick(12);
		rst_n = 1'b1;
		tick(4);
		`CHK("oe tri", 1'b0, oe[0])
		`CHK("pwm tri", 1'b0, pwm[0])
		`CHK("mrg idle", 2'b00, mrg)
		cnt(1, 200, n1);
		`CHK("fixed duty", 50, n1)
		`CHK("oe fixed", 1'b1, oe[1])
		cfg[1] = mk(clmp_pkg::CLMP_IDLE_FIXED, 17'h0000A, 16'h8000, 1'b1, 1'b1);
		tick(300);
		cnt(1, 125, n1);
		`CHK("min period", 62, n1)
		sel = 2'b01;
		phi = 1'b1;
		ov = 2'b11;
		pen = 1'b1;
		tick(1);
		`CHK("pin mrg", 1'b1, mrg[0])
		tick(1);
		`CHK("pin oe", 1'b1, oe[0])
		tick(2);
		`CHK("ign flt", 1'b0, flt[0])
		cnt(0, 200, n0);
		`CHK("slow step", 1'b1, n0 <= 101)
		tick(4000);
		cnt(0, 200, n1);
		`CHK("up high", 1'b1, n1 > n0)
		phi = 1'b0;
		tick(8000);
		cnt(0, 200, n0);
		`CHK("down low", 1'b1, n0 < n1)
		pen = 1'b0;
		tick(3);
		`CHK("pin off", 2'b00, {mrg[0], oe[0]})
		cfg[1] = mk(clmp_pkg::CLMP_IDLE_FIXED, 17'h000C8, 16'h4000, 1'b0, 1'b1);
		bm = 2'b10;
		bh = 2'b10;
		tick(3);
		`CHK("bus mrg", 1'b1, mrg[1])
		`CHK("bus flt", 1'b1, flt[1])
		cnt(1, 200, n0);
		tick(4000);
		cnt(1, 200, n1);
		`CHK("inv pol", 1'b1, n1 < n0)
		// clock enable low: a new command must not be taken and the pins must freeze
		ce = 1'b0;
		pq = pwm;
		bm = 2'b01;
		tick(20);
		`CHK("ce hold mrg", 2'b10, mrg)
		`CHK("ce hold pwm", pq, pwm)
		bm = 2'b10;
		ce = 1'b1;
		// trim toward a nominal far above the rail so the loop must keep raising duty
		cfg[0] = mk(clmp_pkg::CLMP_IDLE_TRIM, 17'h000C8, 16'h0000, 1'b1, 1'b1);
		cfg[0].v_nom = 16'hFFF0;
		tick(3);
		`CHK("trim oe", 1'b1, oe[0])
		`CHK("trim idle", 1'b0, mrg[0])
		cnt(0, 200, n0);
		tick(4000);
		cnt(0, 200, n1);
		`CHK("trim step", 1'b1, n1 > n0)
		// reset in mid-run: every output drops at once
		rst_n = 1'b0;
		tick(1);
		`CHK("reset outs", 8'h00, {pwm, oe, flt, mrg})
		report_and_stop();
	end
endmodule
`default_nettype wire
